/* core/ebram_consts.vh */
// Shared constants for the embedded block RAM and its staging FIFO.
// Notes on behaviour
// - Each port picks its own data width.
// - Bits map LSB to MSB, word by word.
// - Contents optionally preloaded from user flash store.
// - Shared patterns share storage; all-zero needs none.
// - Port inputs and addresses registered before array access.
// - Output register used only when selected.
// - FIFO reports almost-full, full, almost-empty, empty.
// - Read pointer reset returns read pointer home.
// - Full-in and empty-in act as select bit two.
// - FIFO write and read ports run separately.
// - Legal shapes per mode; x18 only PDP/FIFO.
`ifndef EBRAM_CONSTS_VH
`define EBRAM_CONSTS_VH

`define EBRAM_BITS        9216
`define EBRAM_LANES       18
`define EBRAM_LANE_HI     9
`define EBRAM_LOAD_WORD   9

`define EBRAM_MODE_SP     2'h0
`define EBRAM_MODE_TDP    2'h1
`define EBRAM_MODE_PDP    2'h2
`define EBRAM_MODE_FIFO   2'h3

`define EBRAM_SHAPE_X1    3'h0
`define EBRAM_SHAPE_X2    3'h1
`define EBRAM_SHAPE_X4    3'h2
`define EBRAM_SHAPE_X9    3'h3
`define EBRAM_SHAPE_X18   3'h4

`define EBRAM_WIDTH_1     5'h01
`define EBRAM_WIDTH_2     5'h02
`define EBRAM_WIDTH_4     5'h04
`define EBRAM_WIDTH_9     5'h09
`define EBRAM_WIDTH_18    5'h12

`define EBRAM_CAP_NARROW  14'h2000
`define EBRAM_CAP_WIDE    14'h2400

`define EBRAM_LD_BEGIN    3'h0
`define EBRAM_LD_FETCH    3'h1
`define EBRAM_LD_STORE    3'h2
`define EBRAM_LD_CLEAR    3'h3
`define EBRAM_LD_READY    3'h4
`define EBRAM_LD_LAST     10'h3ff

`define EBRAM_STAGE_WIDTH 18
`define EBRAM_STAGE_DEPTH 32
`define EBRAM_STAGE_ADDR  5

`endif

/* core/ebram_stage_fifo.v */
// Small synchronous staging FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`include "ebram_consts.vh"
module ebram_stage_fifo #(
   parameter WIDTH = `EBRAM_STAGE_WIDTH,
   parameter DEPTH = `EBRAM_STAGE_DEPTH,
   parameter ADDR  = `EBRAM_STAGE_ADDR
) (
   // Clock and reset.
   input  wire             clock,
   input  wire             resetn,
   // Filling side.
   input  wire             inValid,
   output wire             inReady,
   input  wire [WIDTH-1:0] inData,
   // Draining side.
   output wire             outValid,
   input  wire             outReady,
   output wire [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] slots [0:DEPTH-1];
   reg [ADDR-1:0]  wrIdx;
   reg [ADDR-1:0]  rdIdx;
   reg [ADDR:0]    count;
   wire            push;
   wire            pop;

   // Full and empty come straight from the occupancy count.
   assign inReady  = (count != DEPTH[ADDR:0]);
   assign outValid = (count != {(ADDR+1){1'b0}});
   assign outData  = slots[rdIdx];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   // Storage has no reset; only the pointers and the count need a defined start.
   always @(posedge clock) begin
      if (push) begin
         slots[wrIdx] <= inData;
      end
   end

   // Pointers wrap naturally because depth is a power of two.
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wrIdx <= {ADDR{1'b0}};
         rdIdx <= {ADDR{1'b0}};
         count <= {(ADDR+1){1'b0}};
      end else begin
         if (push) begin
            wrIdx <= wrIdx + {{(ADDR-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rdIdx <= rdIdx + {{(ADDR-1){1'b0}}, 1'b1};
         end
         if (push && !pop) begin
            count <= count + {{ADDR{1'b0}}, 1'b1};
         end else if (pop && !push) begin
            count <= count - {{ADDR{1'b0}}, 1'b1};
         end
      end
   end
endmodule

/* core/ebram_block_ram.v */
// Embedded block RAM with RAM, ROM and FIFO modes on a single clock.
`timescale 1ns/100ps
`include "ebram_consts.vh"
module ebram_block_ram (
   // Clock and reset.
   input  wire        clock,
   input  wire        resetn,
   // Configuration.
   input  wire [1:0]  mode,
   input  wire [2:0]  widthA,
   input  wire [2:0]  widthB,
   input  wire        outRegSelA,
   input  wire        outRegSelB,
   output wire        shapeError,
   // Preload from the user flash store.
   input  wire        initAllZero,
   input  wire [13:0] flashBase,
   output wire        flashRead,
   output wire [13:0] flashAddr,
   input  wire [8:0]  flashData,
   output wire        configDone,
   // Port A.
   input  wire        rstA,
   input  wire        clkEnA,
   input  wire        outEnA,
   input  wire        selA,
   input  wire        wrEnA,
   input  wire [1:0]  byteEnA,
   input  wire [12:0] addrA,
   input  wire [17:0] dataInA,
   output wire [17:0] dataOutA,
   // Port B.
   input  wire        rstB,
   input  wire        clkEnB,
   input  wire        outEnB,
   input  wire        selB,
   input  wire        wrEnB,
   input  wire [1:0]  byteEnB,
   input  wire [12:0] addrB,
   input  wire [17:0] dataInB,
   output wire [17:0] dataOutB,
   // FIFO write side.
   input  wire        pushValid,
   output wire        pushReady,
   input  wire [17:0] pushData,
   input  wire [2:0]  writePortSelect,
   input  wire [2:0]  writeSelMatch,
   input  wire        fullIn,
   // FIFO read side and flags.
   input  wire [2:0]  readPortSelect,
   input  wire [2:0]  readSelMatch,
   input  wire        emptyIn,
   input  wire        readPointerReset,
   input  wire [13:0] almostFullLevel,
   input  wire [13:0] almostEmptyLevel,
   output wire        almostFullFlag,
   output wire        fullFlag,
   output wire        almostEmptyFlag,
   output wire        emptyFlag
);
   reg         memBits [0:`EBRAM_BITS-1];
   reg [2:0]   ldState;
   reg [9:0]   ldIdx;
   reg [13:0]  regBaseA, regBaseB;
   reg [17:0]  regDinA, regDinB;
   reg [1:0]   regByteA, regByteB;
   reg         regWeA, regWeB, regRdA, regRdB;
   reg [17:0]  outA, outB;
   reg [13:0]  wrPtr, rdPtr, fill;
   wire [17:0] rawA, rawB;
   wire [17:0] stageData;
   wire        stageValid;
   integer     i;

   // Port width code to bit count.
   function [4:0] shapeWidth(input [2:0] code);
      case (code)
         `EBRAM_SHAPE_X1:  shapeWidth = `EBRAM_WIDTH_1;
         `EBRAM_SHAPE_X2:  shapeWidth = `EBRAM_WIDTH_2;
         `EBRAM_SHAPE_X4:  shapeWidth = `EBRAM_WIDTH_4;
         `EBRAM_SHAPE_X9:  shapeWidth = `EBRAM_WIDTH_9;
         `EBRAM_SHAPE_X18: shapeWidth = `EBRAM_WIDTH_18;
         default:          shapeWidth = `EBRAM_WIDTH_1;
      endcase
   endfunction

   // First bit of a word: address times width, so every port sees one bit order.
   function [13:0] shapeBase(input [2:0] code, input [12:0] addr);
      case (code)
         `EBRAM_SHAPE_X1:  shapeBase = {1'b0, addr};
         `EBRAM_SHAPE_X2:  shapeBase = {1'b0, addr[11:0], 1'b0};
         `EBRAM_SHAPE_X4:  shapeBase = {1'b0, addr[10:0], 2'h0};
         `EBRAM_SHAPE_X9:  shapeBase = {1'b0, addr[9:0], 3'h0} + {4'h0, addr[9:0]};
         `EBRAM_SHAPE_X18: shapeBase = {1'b0, addr[8:0], 4'h0} + {4'h0, addr[8:0], 1'b0};
         default:          shapeBase = 14'h0000;
      endcase
   endfunction

   // Usable bits of a shape: the nine-bit shapes reach the spare bits.
   function [13:0] shapeCap(input [2:0] code);
      shapeCap = (code >= `EBRAM_SHAPE_X9) ? `EBRAM_CAP_WIDE : `EBRAM_CAP_NARROW;
   endfunction

   // Wide shape only in the pseudo dual port and FIFO modes.
   function shapeLegal(input [1:0] md, input [2:0] code);
      shapeLegal = (code <= `EBRAM_SHAPE_X18) &&
                   !(code == `EBRAM_SHAPE_X18 && md < `EBRAM_MODE_PDP);
   endfunction

   // Byte lanes only split the wide shape; narrower shapes take the low enable.
   function laneOn(input [1:0] be, input [2:0] code, input integer lane);
      if (code == `EBRAM_SHAPE_X18) begin
         laneOn = (lane >= `EBRAM_LANE_HI) ? be[1] : be[0];
      end else begin
         laneOn = be[0];
      end
   endfunction

   // Pointer step with wrap at the shape capacity.
   function [13:0] ptrStep(input [13:0] ptr, input [4:0] w, input [13:0] cap);
      reg [13:0] sum;
      begin
         sum = ptr + {9'h000, w};
         ptrStep = (sum >= cap) ? sum - cap : sum;
      end
   endfunction

   wire [4:0]  wA       = shapeWidth(widthA);
   wire [4:0]  wB       = shapeWidth(widthB);
   wire [13:0] capW     = shapeCap(widthA);
   wire        fifoMode = (mode == `EBRAM_MODE_FIFO);
   wire        loaded   = (ldState == `EBRAM_LD_READY);
   wire        legal    = shapeLegal(mode, widthA) & shapeLegal(mode, widthB);
   wire        write_port_select      = ({fullIn, writePortSelect[1:0]} == writeSelMatch);
   wire        read_port_select      = ({emptyIn, readPortSelect[1:0]} == readSelMatch);
   wire        fifoPush;
   wire        fifoPop;
   wire        capA;
   wire        capB;
   wire        ldWrite  = (ldState == `EBRAM_LD_STORE) | (ldState == `EBRAM_LD_CLEAR);
   wire [8:0]  ldData   = (ldState == `EBRAM_LD_STORE) ? flashData : 9'h000;
   wire [13:0] ldBase   = {1'b0, ldIdx, 3'h0} + {4'h0, ldIdx};

   assign shapeError = ~legal;
   assign configDone = loaded;
   assign flashRead  = (ldState == `EBRAM_LD_FETCH);
   assign flashAddr  = flashBase + {4'h0, ldIdx};

   // Fill state in bits; flags are compared against the fill register.
   assign fullFlag        = ({1'b0, fill} + {10'h000, wA}) > {1'b0, capW};
   assign emptyFlag       = (fill < {9'h000, wB});
   assign almostFullFlag  = (fill >= almostFullLevel);
   assign almostEmptyFlag = (fill <= almostEmptyLevel);

   // The write side and read side of the FIFO are enabled independently.
   assign fifoPush = fifoMode & loaded & legal & clkEnA & write_port_select & stageValid & ~fullFlag;
   assign fifoPop  = fifoMode & loaded & legal & clkEnB & read_port_select & ~emptyFlag
                     & ~readPointerReset;
   assign capA     = loaded & legal & clkEnA & (~fifoMode | fifoPush);
   assign capB     = loaded & legal & clkEnB & (fifoMode ? fifoPop : (mode != `EBRAM_MODE_SP));

   // Staging buffer ahead of the FIFO write port; a full array stalls its drain.
   ebram_stage_fifo #(
      .WIDTH (`EBRAM_STAGE_WIDTH),
      .DEPTH (`EBRAM_STAGE_DEPTH),
      .ADDR  (`EBRAM_STAGE_ADDR)
   ) stage (
      .clock    (clock),
      .resetn   (resetn),
      .inValid  (pushValid),
      .inReady  (pushReady),
      .inData   (pushData),
      .outValid (stageValid),
      .outReady (fifoPush),
      .outData  (stageData)
   );

   // Preload sequencer: a zero pattern is swept in without touching the flash.
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ldState <= `EBRAM_LD_BEGIN;
         ldIdx   <= 10'h000;
      end else begin
         case (ldState)
            `EBRAM_LD_BEGIN: begin
               ldState <= initAllZero ? `EBRAM_LD_CLEAR : `EBRAM_LD_FETCH;
            end
            `EBRAM_LD_FETCH: begin
               ldState <= `EBRAM_LD_STORE;
            end
            `EBRAM_LD_STORE, `EBRAM_LD_CLEAR: begin
               if (ldIdx == `EBRAM_LD_LAST) begin
                  ldState <= `EBRAM_LD_READY;
               end else begin
                  ldIdx   <= ldIdx + 10'h001;
                  ldState <= (ldState == `EBRAM_LD_STORE) ? `EBRAM_LD_FETCH : ldState;
               end
            end
            `EBRAM_LD_READY: begin
               ldState <= `EBRAM_LD_READY;
            end
            default: begin
               ldState <= `EBRAM_LD_BEGIN;
            end
         endcase
      end
   end

   // Entry registers: no port access reaches the array before it is captured here; preload writes bypass them.
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         regBaseA <= 14'h0000;
         regDinA  <= 18'h00000;
         regByteA <= 2'h0;
         regWeA   <= 1'b0;
         regRdA   <= 1'b0;
         regBaseB <= 14'h0000;
         regDinB  <= 18'h00000;
         regByteB <= 2'h0;
         regWeB   <= 1'b0;
         regRdB   <= 1'b0;
      end else begin
         regWeA <= capA & (fifoMode | (selA & wrEnA));
         regRdA <= capA & ~fifoMode & selA;
         if (capA) begin
            regBaseA <= fifoMode ? wrPtr : shapeBase(widthA, addrA);
            regDinA  <= fifoMode ? stageData : dataInA;
            regByteA <= fifoMode ? 2'h3 : byteEnA;
         end
         regWeB <= capB & (mode == `EBRAM_MODE_TDP) & selB & wrEnB;
         regRdB <= capB & (fifoMode | selB);
         if (capB) begin
            regBaseB <= fifoMode ? rdPtr : shapeBase(widthB, addrB);
            regDinB  <= dataInB;
            regByteB <= byteEnB;
         end
      end
   end

   // Array writes; a same-bit collision goes to the port with the higher lane index for that bit, port B on equal lanes.
   always @(posedge clock) begin
      if (ldWrite) begin
         for (i = 0; i < `EBRAM_LOAD_WORD; i = i + 1) begin
            memBits[ldBase + i] <= ldData[i];
         end
      end else begin
         for (i = 0; i < `EBRAM_LANES; i = i + 1) begin
            if (regWeA && (i < wA) && laneOn(regByteA, widthA, i)) begin
               memBits[regBaseA + i] <= regDinA[i];
            end
            if (regWeB && (i < wB) && laneOn(regByteB, widthB, i)) begin
               memBits[regBaseB + i] <= regDinB[i];
            end
         end
      end
   end

   // Read lanes above a port's width read as zero.
   genvar g;
   generate
      for (g = 0; g < `EBRAM_LANES; g = g + 1) begin : lane
         assign rawA[g] = (g < wA) ? memBits[regBaseA + g] : 1'b0;
         assign rawB[g] = (g < wB) ? memBits[regBaseB + g] : 1'b0;
      end
   endgenerate

   // Optional output registers; in FIFO mode the B enable is the output read enable.
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         outA <= 18'h00000;
         outB <= 18'h00000;
      end else begin
         if (rstA) begin
            outA <= 18'h00000;
         end else if (outEnA && regRdA) begin
            outA <= rawA;
         end
         if (rstB) begin
            outB <= 18'h00000;
         end else if (outEnB && regRdB) begin
            outB <= rawB;
         end
      end
   end

   assign dataOutA = outRegSelA ? outA : rawA;
   assign dataOutB = outRegSelB ? outB : rawB;

   // FIFO pointers and fill; a pointer reset rewinds reads to the start.
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wrPtr <= 14'h0000;
         rdPtr <= 14'h0000;
         fill  <= 14'h0000;
      end else if (!fifoMode) begin
         wrPtr <= 14'h0000;
         rdPtr <= 14'h0000;
         fill  <= 14'h0000;
      end else begin
         if (fifoPush) begin
            wrPtr <= ptrStep(wrPtr, wA, capW);
         end
         if (readPointerReset) begin
            rdPtr <= 14'h0000;
            fill  <= fifoPush ? wrPtr + {9'h000, wA} : wrPtr;
         end else begin
            if (fifoPop) begin
               rdPtr <= ptrStep(rdPtr, wB, capW);
            end
            fill <= fill + (fifoPush ? {9'h000, wA} : 14'h0000)
                         - (fifoPop ? {9'h000, wB} : 14'h0000);
         end
      end
   end
endmodule

/* dv/ebram_flash_model.sv */
// Behavioural model of the user flash store that feeds the preload sweep.
`timescale 1ns/100ps
module ebram_flash_model (
   // Clock.
   input  wire logic       clock,
   // Fetch request from the block.
   input  wire logic       flashRead,
   input  wire logic [13:0] flashAddr,
   // Word returned one cycle later.
   output logic      [8:0]  flashData
);
   initial flashData = 9'h000;
   // Data depends on the address only, so blocks with one base see one pattern.
   // Outside the answer cycle the word is inverted so a late sample never passes by luck.
   always @(posedge clock) begin
      if (flashRead) begin
         flashData <= flashAddr[8:0] ^ {flashAddr[13:9], 4'h5};
      end else begin
         flashData <= ~flashData;
      end
   end
endmodule

/* dv/ebram_block_ram_props.sv */
// Concurrent checks on the ports of the block RAM top level.
`timescale 1ns/100ps
module ebram_checker (
   // Clock, reset and setup.
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic [1:0]  mode,
   input wire logic [2:0]  widthA,
   input wire logic        shapeError,
   // Preload.
   input wire logic        flashRead,
   input wire logic [13:0] flashAddr,
   input wire logic        configDone,
   // Port B output stage and flags.
   input wire logic        outRegSelB,
   input wire logic        outEnB,
   input wire logic        rstB,
   input wire logic [17:0] dataOutB,
   input wire logic        fullFlag,
   input wire logic        emptyFlag
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   // Shape legality is combinational, so it is checked in the same cycle.
   a_shape_wide: assert property (mode < 2'h2 && widthA == 3'h4 |-> shapeError)
      else $error("x18 shape accepted in a narrow mode");
   a_shape_code: assert property (widthA > 3'h4 |-> shapeError)
      else $error("undefined shape code accepted");
   a_flash_pulse: assert property (flashRead |=> !flashRead)
      else $error("flash fetch longer than one cycle");
   a_flash_addr: assert property (flashRead |=> $stable(flashAddr))
      else $error("flash address moved before store");
   a_done_quiet: assert property (configDone |-> !flashRead)
      else $error("flash fetch after preload done");
   a_done_stays: assert property (configDone |=> configDone)
      else $error("preload done dropped without reset");
   a_reg_clear: assert property (rstB && outRegSelB |=> !outRegSelB || dataOutB == 18'h0)
      else $error("output register not cleared");
   a_reg_hold: assert property (outRegSelB && !outEnB && !rstB |=> !outRegSelB || $stable(dataOutB))
      else $error("output register moved while disabled");
   a_empty_idle: assert property (mode != 2'h3 ##1 mode != 2'h3 |-> emptyFlag)
      else $error("empty flag low outside queue mode");
   a_flags_apart: assert property (mode == 2'h3 |-> !(fullFlag && emptyFlag))
      else $error("full and empty together");
endmodule
bind ebram_block_ram ebram_checker ebram_checker_inst (
   .clock(clock), .resetn(resetn), .mode(mode), .widthA(widthA), .shapeError(shapeError),
   .flashRead(flashRead), .flashAddr(flashAddr), .configDone(configDone),
   .outRegSelB(outRegSelB), .outEnB(outEnB), .rstB(rstB), .dataOutB(dataOutB),
   .fullFlag(fullFlag), .emptyFlag(emptyFlag)
);

/* dv/test_embedded_block_ram.sv */
// Self-checking bench for the block RAM: preload, ports, output register and queue mode.
`timescale 1ns/100ps
module test_embedded_block_ram;
   // Design stimulus and responses.
   logic        clock, resetn, initAllZero, outRegSelB, outEnB, rstB, clkEnA, clkEnB, selA;
   logic        selB, wrEnA, pushValid, fullIn, emptyIn, readPointerReset, flashRead;
   logic        shapeError, configDone, pushReady, almostFullFlag, fullFlag;
   logic        almostEmptyFlag, emptyFlag;
   logic [1:0]  mode, byteEnA;
   logic [2:0]  widthA, widthB, writePortSelect, writeSelMatch, readPortSelect, readSelMatch;
   logic [12:0] addrA, addrB;
   logic [13:0] flashBase, almostFullLevel, almostEmptyLevel, flashAddr;
   logic [17:0] dataInA, dataInB, pushData, dataOutA, dataOutB;
   logic [8:0]  flashData;
   // Bench state.
   int          n_errors = 0;
   int          check_count = 0;
   int          cycles = 0;
   logic [31:0] seed;
   logic [8:0]  words[$];

   ebram_block_ram ebram_block_ram_inst (
      .clock(clock), .resetn(resetn), .mode(mode), .widthA(widthA), .widthB(widthB),
      .outRegSelA(1'b0), .outRegSelB(outRegSelB), .shapeError(shapeError),
      .initAllZero(initAllZero), .flashBase(flashBase), .flashRead(flashRead),
      .flashAddr(flashAddr), .flashData(flashData), .configDone(configDone),
      .rstA(1'b0), .clkEnA(clkEnA), .outEnA(1'b1), .selA(selA), .wrEnA(wrEnA),
      .byteEnA(byteEnA), .addrA(addrA), .dataInA(dataInA), .dataOutA(dataOutA),
      .rstB(rstB), .clkEnB(clkEnB), .outEnB(outEnB), .selB(selB), .wrEnB(1'b0),
      .byteEnB(2'h3), .addrB(addrB), .dataInB(dataInB), .dataOutB(dataOutB),
      .pushValid(pushValid), .pushReady(pushReady), .pushData(pushData),
      .writePortSelect(writePortSelect), .writeSelMatch(writeSelMatch), .fullIn(fullIn),
      .readPortSelect(readPortSelect), .readSelMatch(readSelMatch), .emptyIn(emptyIn),
      .readPointerReset(readPointerReset), .almostFullLevel(almostFullLevel),
      .almostEmptyLevel(almostEmptyLevel), .almostFullFlag(almostFullFlag),
      .fullFlag(fullFlag), .almostEmptyFlag(almostEmptyFlag), .emptyFlag(emptyFlag)
   );
   ebram_flash_model ebram_flash_model_inst (
      .clock(clock), .flashRead(flashRead), .flashAddr(flashAddr), .flashData(flashData)
   );

   // Free-running 20 MHz clock.
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected preload word, worked out independently of the flash model.
   function automatic logic [8:0] pattern(input logic [13:0] a);
      return a[8:0] ^ {a[13:9], 4'h5};
   endfunction

   task automatic next_rand(output logic [17:0] r);
      seed = lfsr(seed);
      r = seed[17:0];
   endtask

   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Reset for ten cycles, then wait a bounded time for the preload sweep.
   task automatic restart(input logic zero);
      @(posedge clock);
      resetn <= 1'b0;
      initAllZero <= zero;
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      for (int i = 0; i < 3000 && configDone !== 1'b1; i++) @(posedge clock);
      chk({17'h0, configDone}, 18'h1);
   endtask

   // One port request; returns one step after the capture edge.
   task automatic port_op(input logic b, input logic w, input logic [12:0] a,
                          input logic [17:0] d, input logic [1:0] be);
      @(posedge clock);
      {selA, selB, wrEnA, addrA, addrB} <= {!b, b, w, a, a};
      {dataInA, dataInB, byteEnA} <= {d, ~d, be};
      @(posedge clock);
      {selA, selB, wrEnA} <= 3'h0;
      #1;
   endtask

   task automatic rd(input logic b, input logic [12:0] a, input logic [17:0] exp);
      port_op(b, 1'b0, a, 18'h0, 2'h0);
      chk(b ? dataOutB : dataOutA, exp);
   endtask

   task automatic pop(input logic [8:0] exp);
      @(posedge clock);
      clkEnB <= 1'b1;
      @(posedge clock);
      clkEnB <= 1'b0;
      #1;
      chk(dataOutB, {9'h0, exp});
   endtask

   // A hang counts as a mismatch and ends the run.
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   initial begin
      logic [17:0] d, e;
      logic        ok;
      {initAllZero, outRegSelB, outEnB, rstB, selA, selB, wrEnA, pushValid, fullIn} = '0;
      {emptyIn, readPointerReset, clkEnB, resetn, byteEnA} = '0;
      {clkEnA, seed, mode, widthA, widthB} = {1'b1, 32'h00014ee9, 2'h0, 3'h3, 3'h3};
      {addrA, addrB, dataInA, dataInB, pushData} = '0;
      {writePortSelect, writeSelMatch, readPortSelect, readSelMatch} = 12'h364;
      {flashBase, almostFullLevel, almostEmptyLevel} = {14'h0123, 14'h0024, 14'h0009};
      // Preloaded contents read back as a ROM, writes held off.
      restart(1'b0);
      for (int n = 0; n < 1024; n += 93) begin
         rd(1'b0, n[12:0], {9'h0, pattern(flashBase + n[13:0])});
      end
      rd(1'b0, 13'h03ff, {9'h0, pattern(flashBase + 14'h03ff)});
      $display("preload test done");
      // Wide writes on port A seen as narrow words on port B.
      @(posedge clock);
      {mode, widthA, clkEnB} <= {2'h2, 3'h4, 1'b1};
      repeat (8) begin
         next_rand(d);
         next_rand(e);
         port_op(1'b0, 1'b1, {4'h0, e[8:0]}, d, 2'h3);
         rd(1'b1, {3'h0, e[8:0], 1'b0}, {9'h0, d[8:0]});
         port_op(1'b0, 1'b1, {4'h0, e[8:0]}, ~d, 2'h2);
         rd(1'b1, {3'h0, e[8:0], 1'b0}, {9'h0, d[8:0]});
         @(posedge clock);
         {wrEnA, dataInA} <= {1'b1, d};
         @(posedge clock);
         wrEnA <= 1'b0;
         rd(1'b1, {3'h0, e[8:0], 1'b1}, {9'h0, ~d[17:9]});
      end
      $display("width mapping test done");
      // Output register: load, hold while disabled, clear on reset.
      @(posedge clock);
      {outRegSelB, outEnB} <= 2'h3;
      port_op(1'b1, 1'b0, {3'h0, e[8:0], 1'b0}, 18'h0, 2'h0);
      @(posedge clock);
      #1;
      chk(dataOutB, {9'h0, d[8:0]});
      outEnB <= 1'b0;
      port_op(1'b1, 1'b0, {3'h0, e[8:0], 1'b1}, 18'h0, 2'h0);
      @(posedge clock);
      #1;
      chk(dataOutB, {9'h0, d[8:0]});
      rstB <= 1'b1;
      @(posedge clock);
      #1;
      chk(dataOutB, 18'h0);
      {rstB, outRegSelB} <= 2'h0;
      for (int m = 0; m < 3; m++) begin
         @(posedge clock);
         mode <= m[1:0];
         #1;
         chk({17'h0, shapeError}, {17'h0, m < 2});
      end
      $display("output register and shape test done");
      // Queue mode: fill staging with the write select off, then drain and pop.
      @(posedge clock);
      {mode, widthA, widthB, clkEnB, emptyIn, pushValid} <= {2'h3, 6'h1b, 3'h3};
      repeat (40) begin
         next_rand(d);
         pushData <= d;
         @(negedge clock);
         ok = pushReady;
         @(posedge clock);
         if (ok) words.push_back(d[8:0]);
      end
      pushValid <= 1'b0;
      #1;
      chk(18'(words.size()), 18'h20);
      chk({17'h0, emptyFlag}, 18'h1);
      fullIn <= 1'b1;
      repeat (40) @(posedge clock);
      #1;
      chk({16'h0, almostFullFlag, emptyFlag}, 18'h2);
      pop(words[0]);
      pop(words[1]);
      @(posedge clock);
      readPointerReset <= 1'b1;
      @(posedge clock);
      readPointerReset <= 1'b0;
      foreach (words[i]) pop(words[i]);
      chk({16'h0, almostEmptyFlag, emptyFlag}, 18'h3);
      pop(words[31]);
      @(posedge clock);
      pushValid <= 1'b1;
      repeat (1030) @(posedge clock);
      pushValid <= 1'b0;
      repeat (40) @(posedge clock);
      #1;
      chk({17'h0, fullFlag}, 18'h1);
      $display("queue test done");
      // All-zero preload clears earlier contents without flash reads.
      {mode, widthA} <= {2'h0, 3'h3};
      restart(1'b1);
      rd(1'b0, 13'h0005, 18'h0);
      rd(1'b0, 13'h03ff, 18'h0);
      $display("zero preload test done");
      report_and_stop();
   end
endmodule
